// >>> hdl/pmd_decode.sv
`timescale 1ns/1ps
`include "pmd_defines.svh"

module pmd_decode (
  input  pmd_pkg::pmd_bus_t bus,   // Effective host cycle
  input  wire logic [7:0]   page,  // Effective page value
  output pmd_pkg::pmd_sel_t sel    // Prioritised selects
);

  function automatic logic in_rng(input logic [15:0] a,
                                  input logic [15:0] lo,
                                  input logic [15:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction : in_rng

  // ----------------------------------------------------------------
  // Decode array
  // ----------------------------------------------------------------
  // Data space wins if the host ever flags both, keeping selects one-hot
  always_comb
  begin
    logic       prog;
    logic       data;
    logic [7:0] main;
    logic [3:0] sec;
    logic       sram;
    logic       ctl;
    sec  = 4'h0;
    main = 8'h00;
    prog = bus.fetch & ~(bus.rd | bus.wr);
    data = bus.rd | bus.wr;
    // No hole for core-internal RAM or registers
    sram = data & in_rng(bus.addr, `PMD_SRAM_LO, `PMD_SRAM_HI);
    ctl  = data & in_rng(bus.addr, `PMD_CTL_LO, `PMD_CTL_HI);
    sec[0] = data & in_rng(bus.addr, `PMD_S0_LO, `PMD_S0_HI);
    sec[1] = data & in_rng(bus.addr, `PMD_S1_LO, `PMD_S1_HI);
    sec[2] = data & in_rng(bus.addr, `PMD_S2_LO, `PMD_S2_HI);
    sec[3] = data & in_rng(bus.addr, `PMD_S3_LO, `PMD_S3_HI);
    sec    = sec & {4{~(sram | ctl)}};
    main[0] = prog & in_rng(bus.addr, `PMD_M0_LO, `PMD_M0_HI);
    main[1] = prog & in_rng(bus.addr, `PMD_M1_LO, `PMD_M1_HI);
    for (int p = 0; p < `PMD_NUM_PAGES; p++)
    begin
      main[2 + 2*p] = prog & (page == 8'(p)) &
                      in_rng(bus.addr, `PMD_PG_LO_LO, `PMD_PG_LO_HI);
      main[3 + 2*p] = prog & (page == 8'(p)) &
                      in_rng(bus.addr, `PMD_PG_HI_LO, `PMD_PG_HI_HI);
    end
    // Secondary flash, SRAM and register block all outrank main flash
    main = main & {8{~((|sec) | sram | ctl)}};
    sel.sram_select      = sram;
    sel.ctl_block_sel    = ctl;
    sel.second_flash_sel = sec;
    sel.main_sector_sel  = main;
  end

endmodule : pmd_decode

// >>> hdl/pmd_defines.svh
`ifndef PMD_DEFINES_SVH
`define PMD_DEFINES_SVH

// ----------------------------------------------------------------
// Register offsets on the APB window
// ----------------------------------------------------------------
`define PMD_OFS_PAGE     8'h00
`define PMD_OFS_PWR_A    8'h04
`define PMD_OFS_PWR_C    8'h08
`define PMD_OFS_PROT_M   8'h0c
`define PMD_OFS_PROT_S   8'h10

// ----------------------------------------------------------------
// Reset values and field positions
// ----------------------------------------------------------------
`define PMD_PAGE_RST     8'h00
`define PMD_PWR_A_RST    8'h00
`define PMD_PWR_C_RST    8'h00
`define PMD_LP_BIT       0
`define PMD_BLK_PAGE_BIT 1
`define PMD_BLK_ADDR_BIT 2
`define PMD_BLK_FTCH_BIT 0
`define PMD_BLK_RD_BIT   1
`define PMD_BLK_WR_BIT   2

// ----------------------------------------------------------------
// Address windows of the memory map
// ----------------------------------------------------------------
`define PMD_SRAM_LO      16'h0000
`define PMD_SRAM_HI      16'h1fff
`define PMD_CTL_LO       16'h2000
`define PMD_CTL_HI       16'h20ff
`define PMD_M0_LO        16'h0000
`define PMD_M0_HI        16'h3fff
`define PMD_M1_LO        16'h4000
`define PMD_M1_HI        16'h7fff
`define PMD_PG_LO_LO     16'h8000
`define PMD_PG_LO_HI     16'hbfff
`define PMD_PG_HI_LO     16'hc000
`define PMD_PG_HI_HI     16'hffff
`define PMD_S0_LO        16'h8000
`define PMD_S0_HI        16'h9fff
`define PMD_S1_LO        16'ha000
`define PMD_S1_HI        16'hbfff
`define PMD_S2_LO        16'hc000
`define PMD_S2_HI        16'hdfff
`define PMD_S3_LO        16'he000
`define PMD_S3_HI        16'hffff
`define PMD_NUM_PAGES    3

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define PMD_CLK_MHZ      10
`define PMD_LP_DELAY_NS  200
`define PMD_LP_CYC ((`PMD_LP_DELAY_NS*`PMD_CLK_MHZ+999)/1000)

`endif

// >>> hdl/pmd_lp_gate.sv
`timescale 1ns/1ps
`include "pmd_defines.svh"

module pmd_lp_gate #(
  parameter int W   = 27,          // Width of watched inputs
  parameter int CYC = `PMD_LP_CYC  // Extra delay in low power
) (
  input  wire logic         pclk,    // Clock
  input  wire logic         presetn, // Async reset, low
  input  wire logic         lp_en,   // Low-power mode
  input  wire logic [W-1:0] watch,   // Array inputs
  input  pmd_pkg::pmd_sel_t sel_in,  // Fresh decode
  output pmd_pkg::pmd_sel_t sel_out  // Held selects
);

  logic [W-1:0]          watch_q;
  logic [7:0]            cnt_q;
  pmd_pkg::pmd_lp_state_t st_q;
  pmd_pkg::pmd_sel_t     sel_q;
  logic                  changed;

  assign changed = (watch != watch_q);
  assign sel_out = sel_q;

  // Last seen inputs, to spot a transition
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      watch_q <= '0;
    else
      watch_q <= watch;
  end

  // Fast: follow every cycle. Low power: sleep, wake on change, settle late
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sel_q <= '0;
      st_q  <= pmd_pkg::PMD_SETTLED;
      cnt_q <= 8'h00;
    end
    else if (!lp_en)
    begin
      sel_q <= sel_in;
      st_q  <= pmd_pkg::PMD_SETTLED;
      cnt_q <= 8'h00;
    end
    else if (changed)
    begin
      st_q  <= pmd_pkg::PMD_EVAL;
      cnt_q <= 8'(CYC);
    end
    else
    begin
      case (st_q)
        pmd_pkg::PMD_EVAL:
          if (cnt_q <= 8'h01)
          begin
            sel_q <= sel_in;
            st_q  <= pmd_pkg::PMD_SETTLED;
          end
          else
            cnt_q <= cnt_q - 8'h01;
        default: ;
      endcase
    end
  end

  a_lp_hold_sel: assert property (@(posedge pclk) disable iff (!presetn)
    (lp_en && !changed && st_q == pmd_pkg::PMD_SETTLED) |=> $stable(sel_q))
    else $error("Selects moved while asleep");

endmodule : pmd_lp_gate

// >>> hdl/pmd_pkg.sv
package pmd_pkg;

  // Host cycle as seen by the decode array
  typedef struct packed {
    logic [15:0] addr;   // Host address
    logic        fetch;  // Program-space fetch
    logic        rd;     // Data-space read
    logic        wr;     // Data-space write
  } pmd_bus_t;

  // One chip select per memory element
  typedef struct packed {
    logic       sram_select;
    logic       ctl_block_sel;
    logic [3:0] second_flash_sel;
    logic [7:0] main_sector_sel;
  } pmd_sel_t;

  // Low-power evaluation state
  typedef enum logic [0:0] {
    PMD_SETTLED,
    PMD_EVAL
  } pmd_lp_state_t;

endpackage : pmd_pkg

// >>> hdl/pmd_top.sv
`timescale 1ns/1ps
`include "pmd_defines.svh"

// Function
// - SRAM select for data accesses 0x0000 to 0x1FFF.
// - Register block select for data accesses 0x2000 to 0x20FF.
// - Main sector 0 for program addresses 0x0000 to 0x3FFF, any page.
// - Main sector 1 for program addresses 0x4000 to 0x7FFF, any page.
// - Page 0 maps main sectors 2 and 3 into upper program space.
// - Page 1 maps main sectors 4 and 5 into upper program space.
// - Page 2 maps main sectors 6 and 7 into upper program space.
// - Secondary sectors 0, 1 at data 0x8000-0x9FFF, 0xA000-0xBFFF.
// - Secondary sectors 2, 3 at data 0xC000-0xDFFF, 0xE000-0xFFFF.
// - Main flash on program fetches only; the rest on data cycles.
// - Data selects never carve out core-internal RAM or registers.
// - Arrays fast after reset; writing low-power bit 1 slows them.
// - In low power, hold selects until inputs change, then settle late.
// - Two power control registers hold bits blocking array inputs.
// - Two read-only registers report sector write protection.
// - Eight-bit page register, read and written, drives decoding.
// - Page register clears to zero on reset.
// - Secondary flash outranks main flash where they overlap.
// - SRAM and register block outrank any flash sector.

module pmd_top #(
  parameter int LP_CYC = `PMD_LP_CYC  // Low-power settle cycles
) (
  input  wire logic         pclk,           // APB clock
  input  wire logic         presetn,        // Async reset, low
  input  wire logic         psel,           // APB select
  input  wire logic         penable,        // APB enable
  input  wire logic         pwrite,         // APB direction
  input  wire logic [7:0]   paddr,          // APB byte address
  input  wire logic [31:0]  pwdata,         // APB write data
  output logic [31:0]       prdata,         // APB read data
  output logic              pready,         // APB ready
  output logic              pslverr,        // APB error
  input  pmd_pkg::pmd_bus_t host_bus,       // Host cycle
  input  wire logic [7:0]   main_protect,   // Main sector lock
  input  wire logic [3:0]   second_protect, // Secondary lock
  output pmd_pkg::pmd_sel_t sel             // Chip selects
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [7:0]        page_q;
  logic [7:0]        pwr_a_q;
  logic [7:0]        pwr_c_q;
  logic [31:0]       prdata_q;
  logic              pready_q;
  logic              pslverr_q;
  logic              access;
  logic              fire;
  logic              wr_fire;
  logic [7:0]        rd_byte;
  pmd_pkg::pmd_bus_t held_bus_q;
  logic [7:0]        held_page_q;
  pmd_pkg::pmd_bus_t eff_bus;
  logic [7:0]        eff_page;
  pmd_pkg::pmd_sel_t dec_sel;
  logic              lp_en;

  function automatic logic is_mapped(input logic [7:0] a);
    return (a == `PMD_OFS_PAGE)   || (a == `PMD_OFS_PWR_A) ||
           (a == `PMD_OFS_PWR_C)  || (a == `PMD_OFS_PROT_M) ||
           (a == `PMD_OFS_PROT_S);
  endfunction : is_mapped

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  // One wait state so read data and ready can come from flops
  assign access  = psel & penable;
  assign fire    = access & pready_q;
  assign wr_fire = fire & pwrite;
  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;

  // Read mux; protection bits are live status, not stored
  always_comb
  begin
    rd_byte = 8'h00;
    case (paddr)
      `PMD_OFS_PAGE:   rd_byte = page_q;
      `PMD_OFS_PWR_A:  rd_byte = pwr_a_q;
      `PMD_OFS_PWR_C:  rd_byte = pwr_c_q;
      `PMD_OFS_PROT_M: rd_byte = main_protect;
      `PMD_OFS_PROT_S: rd_byte = {4'h0, second_protect};
      default:         rd_byte = 8'h00;
    endcase
  end

  // Ready toggles up for exactly one cycle per access phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pready_q <= 1'b0;
    else
      pready_q <= access & ~pready_q;
  end

  // Read data and error are captured together with ready
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_q  <= 32'h00000000;
      pslverr_q <= 1'b0;
    end
    else if (access & ~pready_q)
    begin
      prdata_q  <= {24'h000000, rd_byte};
      pslverr_q <= ~is_mapped(paddr);
    end
    else
    begin
      prdata_q  <= 32'h00000000;
      pslverr_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  // Page register feeds the paged main flash decode
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      page_q <= `PMD_PAGE_RST;
    else if (wr_fire && paddr == `PMD_OFS_PAGE)
      page_q <= pwdata[7:0];
  end

  // Low-power bit and input-block bits, register A
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pwr_a_q <= `PMD_PWR_A_RST;
    else if (wr_fire && paddr == `PMD_OFS_PWR_A)
      pwr_a_q <= pwdata[7:0];
  end

  // Cycle-type block bits, register C
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pwr_c_q <= `PMD_PWR_C_RST;
    else if (wr_fire && paddr == `PMD_OFS_PWR_C)
      pwr_c_q <= pwdata[7:0];
  end

  // Protection status offsets accept writes but store nothing
  assign lp_en = pwr_a_q[`PMD_LP_BIT];

  // ----------------------------------------------------------------
  // Input blocking
  // ----------------------------------------------------------------
  // A blocked input is frozen at its last value, so the array sees no
  // transitions from it; software must block only idle signals
  always_comb
  begin
    eff_bus  = host_bus;
    eff_page = page_q;
    if (pwr_a_q[`PMD_BLK_PAGE_BIT])
      eff_page = held_page_q;
    if (pwr_a_q[`PMD_BLK_ADDR_BIT])
      eff_bus.addr = held_bus_q.addr;
    if (pwr_c_q[`PMD_BLK_FTCH_BIT])
      eff_bus.fetch = held_bus_q.fetch;
    if (pwr_c_q[`PMD_BLK_RD_BIT])
      eff_bus.rd = held_bus_q.rd;
    if (pwr_c_q[`PMD_BLK_WR_BIT])
      eff_bus.wr = held_bus_q.wr;
  end

  // Hold what the array last saw
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      held_bus_q  <= '0;
      held_page_q <= 8'h00;
    end
    else
    begin
      held_bus_q  <= eff_bus;
      held_page_q <= eff_page;
    end
  end

  // ----------------------------------------------------------------
  // Decode and power gate
  // ----------------------------------------------------------------
  pmd_decode u_decode (
    .bus  (eff_bus),
    .page (eff_page),
    .sel  (dec_sel)
  );

  // Selects leave through a flop; in low power the host must allow
  // the extra settle cycles with a wait state
  pmd_lp_gate #(
    .W   ($bits(pmd_pkg::pmd_bus_t) + 8),
    .CYC (LP_CYC)
  ) u_lp_gate (
    .pclk    (pclk),
    .presetn (presetn),
    .lp_en   (lp_en),
    .watch   ({eff_bus, eff_page}),
    .sel_in  (dec_sel),
    .sel_out (sel)
  );

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_sram_window: assert property (@(posedge pclk) disable iff (!presetn)
    (!lp_en && (eff_bus.rd || eff_bus.wr) && !eff_bus.fetch &&
     eff_bus.addr <= `PMD_SRAM_HI) |=> sel.sram_select)
    else $error("SRAM select missing");

  a_ctl_window: assert property (@(posedge pclk) disable iff (!presetn)
    (!lp_en && (eff_bus.rd || eff_bus.wr) &&
     eff_bus.addr >= `PMD_CTL_LO && eff_bus.addr <= `PMD_CTL_HI)
    |=> sel.ctl_block_sel)
    else $error("Register block select missing");

  a_common_low: assert property (@(posedge pclk) disable iff (!presetn)
    (!lp_en && eff_bus.fetch && !eff_bus.rd && !eff_bus.wr &&
     eff_bus.addr <= `PMD_M0_HI) |=> sel.main_sector_sel == 8'h01)
    else $error("Main sector 0 select wrong");

  a_common_high: assert property (@(posedge pclk) disable iff (!presetn)
    (!lp_en && eff_bus.fetch && !eff_bus.rd && !eff_bus.wr &&
     eff_bus.addr[15:14] == 2'b01) |=> sel.main_sector_sel == 8'h02)
    else $error("Main sector 1 select wrong");

  a_page_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (!lp_en && eff_bus.fetch && !eff_bus.rd && !eff_bus.wr &&
     eff_page == 8'h00 && eff_bus.addr[15])
    |=> sel.main_sector_sel == ($past(eff_bus.addr[14]) ? 8'h08 : 8'h04))
    else $error("Page 0 sector wrong");

  a_page_one: assert property (@(posedge pclk) disable iff (!presetn)
    (!lp_en && eff_bus.fetch && !eff_bus.rd && !eff_bus.wr &&
     eff_page == 8'h01 && eff_bus.addr[15])
    |=> sel.main_sector_sel == ($past(eff_bus.addr[14]) ? 8'h20 : 8'h10))
    else $error("Page 1 sector wrong");

  a_page_two: assert property (@(posedge pclk) disable iff (!presetn)
    (!lp_en && eff_bus.fetch && !eff_bus.rd && !eff_bus.wr &&
     eff_page == 8'h02 && eff_bus.addr[15])
    |=> sel.main_sector_sel == ($past(eff_bus.addr[14]) ? 8'h80 : 8'h40))
    else $error("Page 2 sector wrong");

  a_second_sel: assert property (@(posedge pclk) disable iff (!presetn)
    (!lp_en && (eff_bus.rd || eff_bus.wr) && eff_bus.addr[15])
    |=> sel.second_flash_sel == 4'(4'h1 << $past(eff_bus.addr[14:13])))
    else $error("Secondary select wrong");

  a_space_split: assert property (@(posedge pclk) disable iff (!presetn)
    (sel.main_sector_sel != 8'h00) |-> (sel.second_flash_sel == 4'h0 &&
     !sel.sram_select && !sel.ctl_block_sel))
    else $error("Main and data selects together");

  a_one_hot: assert property (@(posedge pclk) disable iff (!presetn)
    $onehot0(sel))
    else $error("More than one select active");

  a_page_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_fire && paddr == `PMD_OFS_PAGE) |=> page_q == $past(pwdata[7:0]))
    else $error("Page register not written");

  a_lp_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_fire && paddr == `PMD_OFS_PWR_A) |=> lp_en == $past(pwdata[0]))
    else $error("Low-power bit not written");

  a_prot_ro: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_fire && (paddr == `PMD_OFS_PROT_M || paddr == `PMD_OFS_PROT_S))
    |=> ($stable(page_q) && $stable(pwr_a_q) && $stable(pwr_c_q)))
    else $error("Write to status register had effect");

  a_block_page: assert property (@(posedge pclk) disable iff (!presetn)
    pwr_a_q[`PMD_BLK_PAGE_BIT] |-> $stable(eff_page))
    else $error("Blocked page reached array");

  a_apb_answer: assert property (@(posedge pclk) disable iff (!presetn)
    (access && !pready_q) |=> pready_q ##1 !pready_q)
    else $error("Ready not one cycle after access");

  // ----------------------------------------------------------------
  // Map edges, register reads and writes, and input freezing
  // ----------------------------------------------------------------
  a_second_high: assert property (@(posedge pclk) disable iff (!presetn)
    (!lp_en && (eff_bus.rd || eff_bus.wr) && eff_bus.addr[15:14] == 2'b11)
    |=> sel.second_flash_sel == ($past(eff_bus.addr[13]) ? 4'h8 : 4'h4))
    else $error("Upper secondary select wrong");

  a_page_high: assert property (@(posedge pclk) disable iff (!presetn)
    (!lp_en && eff_bus.fetch && !eff_bus.rd && !eff_bus.wr &&
     eff_page > 8'h02 && eff_bus.addr[15]) |=> sel.main_sector_sel == 8'h00)
    else $error("Unmapped page selected flash");

  a_data_gap: assert property (@(posedge pclk) disable iff (!presetn)
    (!lp_en && (eff_bus.rd || eff_bus.wr) && !eff_bus.addr[15] &&
     eff_bus.addr > `PMD_CTL_HI) |=> sel == '0)
    else $error("Select in unmapped data gap");

  a_page_read: assert property (@(posedge pclk) disable iff (!presetn)
    (access && !pready_q && !pwrite && paddr == `PMD_OFS_PAGE)
    |=> prdata[7:0] == $past(page_q))
    else $error("Page register read wrong");

  a_prot_read: assert property (@(posedge pclk) disable iff (!presetn)
    (access && !pready_q && !pwrite && paddr == `PMD_OFS_PROT_M)
    |=> prdata[7:0] == $past(main_protect))
    else $error("Protection status read wrong");

  a_pwr_c_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_fire && paddr == `PMD_OFS_PWR_C) |=> pwr_c_q == $past(pwdata[7:0]))
    else $error("Power register C not written");

  a_block_addr: assert property (@(posedge pclk) disable iff (!presetn)
    pwr_a_q[`PMD_BLK_ADDR_BIT] |-> $stable(eff_bus.addr))
    else $error("Blocked address reached array");

  a_block_read: assert property (@(posedge pclk) disable iff (!presetn)
    pwr_c_q[`PMD_BLK_RD_BIT] |-> $stable(eff_bus.rd))
    else $error("Blocked read strobe reached array");

  // No disable here, so the first edge after release is seen
  a_page_reset: assert property (@(posedge pclk)
    $rose(presetn) |-> page_q == `PMD_PAGE_RST)
    else $error("Page not cleared by reset");

  a_lp_reset: assert property (@(posedge pclk)
    $rose(presetn) |-> !lp_en)
    else $error("Low power on after reset");

endmodule : pmd_top

// >>> sim/paged_memory_decoder_tb_top.sv
`timescale 1ns/1ps
`include "pmd_defines.svh"

module paged_memory_decoder_tb_top;
  localparam int LPC = 2; // Low-power settle cycles
  logic              pclk;
  logic              presetn;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [7:0]        paddr;
  logic [31:0]       pwdata;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic              cyc_valid;
  pmd_pkg::pmd_bus_t cyc;
  pmd_pkg::pmd_bus_t host_bus;
  logic [7:0]        main_protect;
  logic [3:0]        second_protect;
  pmd_pkg::pmd_sel_t sel;
  int                failures;
  int                cmp_count;
  logic [15:0]       da [14] = '{16'h0000, 16'h1fff, 16'h2000, 16'h20ff,
    16'h2100, 16'h7fff, 16'h8000, 16'h9fff, 16'ha000, 16'hbfff,
    16'hc000, 16'hdfff, 16'he000, 16'hffff};
  logic [15:0]       fa [8] = '{16'h0000, 16'h3fff, 16'h4000, 16'h7fff,
    16'h8000, 16'hbfff, 16'hc000, 16'hffff};

  pmd_top #(.LP_CYC(LPC)) i_pmd_top (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .host_bus(host_bus),
    .main_protect(main_protect), .second_protect(second_protect),
    .sel(sel));
  pmd_host_model i_pmd_host_model (.pclk(pclk), .presetn(presetn),
    .cyc_valid(cyc_valid), .cyc(cyc), .host_bus(host_bus));

  // ----------------------------------------------------------------
  // Clock and hang guard
  // ----------------------------------------------------------------
  initial
  begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  initial
  begin
    #9000000;
    failures++;
    conclude();
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic conclude();
    $display("Compares %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : conclude

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  // APB master: hold the request until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [31:0] exp,
                     input logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
    begin
      failures++;
      conclude();
    end
    if (!w)
      check(prdata, exp);
    check({31'h0, pslverr}, {31'h0, e});
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Present a host cycle {addr, fetch, rd, wr}
  task automatic drive(input logic [18:0] v);
    @(posedge pclk);
    cyc       <= v;
    cyc_valid <= 1'b1;
    repeat (2) @(posedge pclk);
    #1;
  endtask : drive

  // Selects worked out from the memory map
  function automatic pmd_pkg::pmd_sel_t exp_sel(input logic [18:0] v,
                                                input logic [7:0] pg);
    pmd_pkg::pmd_sel_t s;
    logic [15:0]       a;
    a = v[18:3];
    s = '0;
    if (v[1] || v[0])
    begin
      if (a <= 16'h1fff)
        s.sram_select = 1'b1;
      else if (a <= 16'h20ff)
        s.ctl_block_sel = 1'b1;
      else if (a[15])
        s.second_flash_sel[a[14:13]] = 1'b1;
    end
    else if (v[2])
    begin
      if (!a[15])
        s.main_sector_sel[a[14]] = 1'b1;
      else if (pg < 8'h03)
        s.main_sector_sel[2 * pg[1:0] + a[14] + 2] = 1'b1;
    end
    return s;
  endfunction : exp_sel

  task automatic expect_sel(input logic [18:0] v, input logic [7:0] pg);
    check({18'h0, sel}, {18'h0, exp_sel(v, pg)});
  endtask : expect_sel

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    failures = 0;
    cmp_count = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    cyc_valid = 1'b0;
    cyc = '0;
    main_protect = 8'h5a;
    second_protect = 4'h9;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    // Reset state and read-only status
    expect_sel(19'h0, 8'h00);
    apb(1'b0, `PMD_OFS_PAGE, 0, 32'h0, 1'b0);
    apb(1'b0, `PMD_OFS_PWR_A, 0, 32'h0, 1'b0);
    apb(1'b0, `PMD_OFS_PWR_C, 0, 32'h0, 1'b0);
    apb(1'b0, `PMD_OFS_PROT_M, 0, 32'h5a, 1'b0);
    apb(1'b1, `PMD_OFS_PROT_M, 32'ha5, 0, 1'b0);
    apb(1'b0, `PMD_OFS_PROT_M, 0, 32'h5a, 1'b0);
    apb(1'b0, `PMD_OFS_PROT_S, 0, 32'h9, 1'b0);
    apb(1'b0, 8'h14, 0, 32'h0, 1'b1);
    apb(1'b1, 8'h14, 32'h1, 0, 1'b1);
    apb(1'b1, `PMD_OFS_PWR_C, 32'hf8, 0, 1'b0);
    apb(1'b0, `PMD_OFS_PWR_C, 0, 32'hf8, 1'b0);
    apb(1'b1, `PMD_OFS_PWR_C, 32'h0, 0, 1'b0);
    // Full map over pages 0..3, reads, writes and fetches
    for (int p = 0; p < 4; p++)
    begin
      apb(1'b1, `PMD_OFS_PAGE, 32'hffffff00 | p, 0, 1'b0);
      apb(1'b0, `PMD_OFS_PAGE, 0, p, 1'b0);
      for (int i = 0; i < 14; i++)
      begin
        drive({da[i], 1'b0, i[0], ~i[0]});
        expect_sel({da[i], 1'b0, i[0], ~i[0]}, p);
        drive({da[i], 3'b100});
        expect_sel({da[i], 3'b100}, p);
        drive({da[i], 3'b110});
        expect_sel({da[i], 3'b110}, p);
      end
      for (int i = 0; i < 8; i++)
      begin
        drive({fa[i], 3'b100});
        expect_sel({fa[i], 3'b100}, p);
      end
    end
    // Idle bus selects nothing
    @(posedge pclk);
    cyc_valid <= 1'b0;
    repeat (3) @(posedge pclk);
    #1;
    expect_sel(19'h0, 8'h03);
    // Low power: held until an input changes, then late update
    drive({16'h0000, 3'b010});
    apb(1'b1, `PMD_OFS_PWR_A, 32'h1, 0, 1'b0);
    repeat (3) @(posedge pclk);
    #1;
    expect_sel({16'h0000, 3'b010}, 8'h03);
    // The host holds each cycle well past the extra delay
    @(posedge pclk);
    cyc <= {16'ha000, 3'b010};
    repeat (LPC + 1) @(posedge pclk);
    #1;
    expect_sel({16'h0000, 3'b010}, 8'h03);
    @(posedge pclk);
    #1;
    expect_sel({16'ha000, 3'b010}, 8'h03);
    apb(1'b1, `PMD_OFS_PWR_A, 32'h0, 0, 1'b0);
    // Input blocking: address, read strobe, page
    drive({16'h0000, 3'b010});
    apb(1'b1, `PMD_OFS_PWR_A, 32'h4, 0, 1'b0);
    drive({16'h8000, 3'b010});
    expect_sel({16'h0000, 3'b010}, 8'h03);
    apb(1'b1, `PMD_OFS_PWR_A, 32'h0, 0, 1'b0);
    apb(1'b1, `PMD_OFS_PWR_C, 32'h2, 0, 1'b0);
    drive({16'h8000, 3'b100});
    expect_sel({16'h8000, 3'b110}, 8'h03);
    apb(1'b1, `PMD_OFS_PWR_C, 32'h0, 0, 1'b0);
    apb(1'b1, `PMD_OFS_PAGE, 32'h1, 0, 1'b0);
    apb(1'b1, `PMD_OFS_PWR_A, 32'h2, 0, 1'b0);
    apb(1'b1, `PMD_OFS_PAGE, 32'h2, 0, 1'b0);
    drive({16'hc000, 3'b100});
    expect_sel({16'hc000, 3'b100}, 8'h01);
    apb(1'b1, `PMD_OFS_PWR_A, 32'h0, 0, 1'b0);
    drive({16'hc000, 3'b100});
    expect_sel({16'hc000, 3'b100}, 8'h02);
    // Second reset in mid-run clears page and selects
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    #1;
    expect_sel(19'h0, 8'h00);
    presetn <= 1'b1;
    apb(1'b0, `PMD_OFS_PAGE, 0, 32'h0, 1'b0);
    conclude();
  end
endmodule : paged_memory_decoder_tb_top

// >>> sim/pmd_host_model.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Host core bus model
// ----------------------------------------------------------------
module pmd_host_model (
  input  wire logic         pclk,      // Clock
  input  wire logic         presetn,   // Async reset, low
  input  wire logic         cyc_valid, // Cycle requested
  input  pmd_pkg::pmd_bus_t cyc,       // Requested cycle
  output pmd_pkg::pmd_bus_t host_bus   // Bus to decoder
);
  // One cycle per edge; when idle, strobes drop and the address
  // wanders so that a decoder relying on stale lines is caught
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      host_bus <= '0;
    else if (cyc_valid)
      host_bus <= cyc;
    else
    begin
      host_bus.addr  <= ~host_bus.addr;
      host_bus.fetch <= 1'b0;
      host_bus.rd    <= 1'b0;
      host_bus.wr    <= 1'b0;
    end
  end
endmodule : pmd_host_model
